// ---- tb.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errTotal++; \
  $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module tb;
  typedef struct {logic [31:0] e; logic [31:0] m;} tmpc_note_s;
  logic        sys_clk, reset, standby, avs_read, avs_write, avs_waitrequest;
  logic        quadratureInA, quadratureInB, irq, pinLook;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [3:0]  avs_byteenable;
  logic [1:0]  captureIn;
  logic [4:0]  pwmPin, pwmOe;
  int          errTotal = 0, nTests = 0, cyc = 0;
  integer      seed = 32'h4728;
  tmpc_note_s  notes[$];

  tmpc_timer u_dut (.sys_clk(sys_clk), .reset(reset), .standby(standby),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .quadratureInA(quadratureInA), .quadratureInB(quadratureInB),
    .captureIn(captureIn), .pwmPin(pwmPin), .pwmOe(pwmOe), .irq(irq));
  tmpc_quad_model u_enc (.sys_clk(sys_clk), .quadA(quadratureInA),
    .quadB(quadratureInB), .capPin(captureIn));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      giveVerdict();
    end
  end

  // One idle edge before each request, so strobes never change twice in a step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    bus(1'b0, a, 32'h0);
  endtask
  // Pin snapshot: {irq, pwmOe, pwmPin} taken at the falling edge after the next rising edge
  task automatic look(input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk);
    notes.push_back('{e, m});
    pinLook <= 1'b1;
    @(negedge sys_clk);
    pinLook <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
  endtask

  // Checker side: oldest note against whatever result shows now
  always @(negedge sys_clk) begin
    tmpc_note_s nt;
    logic [31:0] v;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 || pinLook === 1'b1) begin
      v = pinLook ? {21'h0, irq, pwmOe, pwmPin} : avs_readdata;
      nt = notes.pop_front();
      `CHK(v & nt.m, nt.e & nt.m)
    end
  end

  initial begin
    {reset, standby, avs_read, avs_write, pinLook} = 5'h10;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h00, 32'h80, 32'hFF);
    rd(8'h04, 32'hC0, 32'hFF);
    rd(8'h08, 32'hFF, 32'hFF);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'hC0, 32'hFF);
    rd(8'h4C, 32'h0, 32'hFFFFFFFF);
    // Random mode values and every combination code
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(8'h00, {24'h0, r[7:0]});
      rd(8'h00, {24'h0, r[7:0] | 8'h80}, 32'hFF);
      wr(8'h04, {26'h0, i[1:0], r[11:8]});
      rd(8'h04, {24'h0, 2'h3, i[1:0], r[11:8]}, 32'hFF);
    end
    $display("test registers done");
    wr(8'h00, 32'h7F);
    wr(8'h04, 32'h3F);
    @(posedge sys_clk) standby <= 1'b1;
    repeat (3) @(posedge sys_clk);
    standby <= 1'b0;
    rd(8'h00, 32'h80, 32'hFF);
    rd(8'h04, 32'hC0, 32'hFF);
    rd(8'h08, 32'hFF, 32'hFF);
    $display("test standby done");
    // Counter write to a synced channel presets it and its partner, not the unsynced channel 2
    wr(8'h10, 32'h3);
    wr(8'h40, 32'h1234);
    rd(8'h50, 32'h1234, 32'hFFFF);
    rd(8'h60, 32'h0, 32'hFFFF);
    wr(8'h10, 32'h0);
    wr(8'h40, 32'h0);
    $display("test sync done");
    // Channel 0 PWM: high from match A at 2 to match B at 5, period 6
    wr(8'h44, 32'h2);
    wr(8'h48, 32'h5);
    wr(8'h14, 32'h4);
    wr(8'h00, 32'h1);
    wr(8'h0C, 32'h1);
    while (pwmPin[0] !== 1'b0) @(negedge sys_clk);
    while (pwmPin[0] !== 1'b1) @(negedge sys_clk);
    for (int i = 0; i < 6; i++) look((i < 2 || i == 5) ? 32'h21 : 32'h20, 32'h21);
    // Counters halted before any combined mode is chosen
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h0);
    $display("test pwm done");
    // Combined modes own the enables of channels 3 and 4
    // Sync bits of 3 and 4 stay clear while complementary mode is on
    wr(8'h04, 32'h20);
    settle();
    look(32'h300, 32'h300);
    wr(8'h08, 32'hFE);
    settle();
    look(32'h200, 32'h300);
    wr(8'h08, 32'hFF);
    wr(8'h04, 32'h10);
    settle();
    look(32'h0, 32'h300);
    wr(8'h00, 32'h08);
    settle();
    look(32'h100, 32'h300);
    wr(8'h04, 32'h30);
    settle();
    look(32'h300, 32'h300);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
    $display("test combine done");
    // Buffered compare A3 reloads from its buffer on match
    wr(8'h90, 32'h7);
    wr(8'h74, 32'h3);
    wr(8'h04, 32'h01);
    wr(8'h0C, 32'h8);
    settle();
    wr(8'h0C, 32'h0);
    rd(8'h74, 32'h7, 32'hFFFF);
    wr(8'h04, 32'h0);
    $display("test buffer done");
    // Quadrature on channel 2 with the slowest prescale, which must not matter
    wr(8'h14, 32'h3);
    wr(8'h20, 32'h4);
    wr(8'h00, 32'h40);
    wr(8'h0C, 32'h4);
    repeat (4) u_enc.step(1'b1);
    settle();
    rd(8'h60, 32'h4, 32'hFFFF);
    repeat (6) u_enc.step(1'b0);
    settle();
    rd(8'h60, 32'hFFFE, 32'hFFFF);
    rd(8'h18, 32'h4, 32'h4);
    look(32'h400, 32'h400);
    wr(8'h20, 32'h0);
    settle();
    look(32'h0, 32'h400);
    wr(8'h1C, 32'h3FF);
    rd(8'h18, 32'h0, 32'h3FF);
    // Underflow from zero must not flag with direction bit set
    wr(8'h00, 32'h60);
    wr(8'h60, 32'h0);
    u_enc.step(1'b0);
    settle();
    rd(8'h18, 32'h0, 32'h4);
    u_enc.step(1'b1);
    settle();
    rd(8'h18, 32'h4, 32'h4);
    $display("test phase done");
    giveVerdict();
  end
endmodule // tb

// ---- tmpc_pkg.sv ----
package tmpc_pkg;
  // Channel layout
  localparam int NUM_CH    = 5;
  localparam int CNT_W     = 16;
  localparam int CH_PHASE  = 2;
  localparam int CH_CMB_LO = 3;
  localparam int NUM_BUF   = 4;
  localparam int DIV_W     = 3;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_FUNC     = 8'h04;
  localparam logic [7:0] OFF_OMEN     = 8'h08;
  localparam logic [7:0] OFF_START    = 8'h0C;
  localparam logic [7:0] OFF_SYNC     = 8'h10;
  localparam logic [7:0] OFF_CTRL     = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h1C;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h20;
  // Channel n page at 0x40 + n*0x10, buffer page at 0x90
  localparam logic [3:0] PAGE_CH_LO   = 4'h4;
  localparam logic [3:0] PAGE_CH_HI   = 4'h8;
  localparam logic [3:0] PAGE_BUF     = 4'h9;
  localparam logic [1:0] SEL_CNT      = 2'h0;
  localparam logic [1:0] SEL_CMPA     = 2'h1;
  localparam logic [1:0] SEL_CMPB     = 2'h2;

  // Reset values and bits that always read as one
  localparam logic [7:0]  MODE_RST   = 8'h80;
  localparam logic [7:0]  MODE_FIXED = 8'h80;
  localparam logic [7:0]  FUNC_RST   = 8'hC0;
  localparam logic [7:0]  FUNC_FIXED = 8'hC0;
  localparam logic [7:0]  OMEN_RST   = 8'hFF;
  localparam logic [7:0]  OMEN_FIXED = 8'hC0;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CMP_RST    = 16'hFFFF;

  // Field positions
  localparam int MODE_PHASE_BIT = 6;
  localparam int MODE_FLAG_DIRECTION_BIT  = 5;
  localparam int FUNC_CMD_LSB   = 4;
  localparam logic [1:0] CMD_COMPL = 2'h2;
  localparam logic [1:0] CMD_RSYNC = 2'h3;
  localparam int OMEN_EA3_BIT   = 0;
  localparam int OMEN_EA4_BIT   = 1;
  localparam int CTRL_W         = 9;
  localparam int CTRL_PSC_LSB   = 0;
  localparam int CTRL_CLRB_LSB  = 2;
  localparam int CTRL_CAP_LSB   = 7;
  localparam logic [1:0] PSC_DIV1 = 2'h0;
  localparam logic [1:0] PSC_DIV2 = 2'h1;
  localparam logic [1:0] PSC_DIV4 = 2'h2;
  localparam int IRQ_W          = 10;
  localparam int IRQ_OVF_LSB    = 0;
  localparam int IRQ_CMPA_LSB   = 5;
endpackage

// ---- tmpc_quad_model.sv ----
`timescale 1ns/10ps
// Encoder on the channel 2 count pins; capture pins idle low
module tmpc_quad_model (
  input  wire logic       sys_clk,
  output logic            quadA,
  output logic            quadB,
  output logic      [1:0] capPin
);
  logic [1:0] phase;

  // Rest at A low, B low; nothing moves between steps
  initial begin
    phase = 2'h0;
    quadA = 1'b0;
    quadB = 1'b0;
    capPin = 2'h0;
  end

  // One edge per call, held well past the three-cycle pin spacing
  task automatic step(input logic up);
    @(posedge sys_clk);
    phase = up ? phase - 2'h1 : phase + 2'h1;
    quadA <= phase[0] ^ phase[1];
    quadB <= phase[1];
    repeat (5) @(posedge sys_clk);
  endtask
endmodule // tmpc_quad_model

// ---- tmpc_timer.sv ----
`timescale 1ns/10ps
// What this block does
// [RQ1] Mode register resets to 0x80 on reset or standby; bit 7 reads one.
// [RQ2] Phase select bit 6 makes channel 2 an up/down counter on quadrature pins.
// [RQ3] Both edges of both quadrature inputs count, direction from the other input.
// [RQ4] Phase counting overrides the channel 2 prescaler selection.
// [RQ5] Channel 2 clear, compare, interrupt and flags keep working in phase mode.
// [RQ6] Flag direction 0: overflow flag on overflow or underflow; 1: overflow only.
// [RQ7] PWM select bit makes the A pin high on compare A, low on compare B.
// [RQ8] Complementary or reset-synchronised mode ignores PWM select of channels 3, 4.
// [RQ9] Function register resets to 0xC0 on reset or standby; bits 7, 6 read one.
// [RQ10] Combination field: 00/01 normal, 10 complementary, 11 reset-synchronised PWM.
// [RQ11] Software stops the counters before entering a combined PWM mode.
// [RQ12] Sync bits of channels 3 and 4 stay in force in combined modes.
// [RQ13] Software never sets both sync bits 3 and 4 in complementary mode.
// [RQ14] Buffer bits 3..0 buffer compare B4, A4, B3, A3; reset unbuffered.
// [RQ15] Output master enable resets to 0xFF on reset or standby; bits 7, 6 read one.
// [RQ16] Synchronised channels are preset and cleared together; others independently.
// [RQ17] Buffered compare loads from buffer on match; capture pushes old value to buffer.
module tmpc_timer (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        standby,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        quadratureInA,
  input  wire logic        quadratureInB,
  input  wire logic [1:0]  captureIn,
  output logic      [4:0]  pwmPin,
  output logic      [4:0]  pwmOe,
  output logic             irq
);
  localparam int NCH = tmpc_pkg::NUM_CH;

  // Merge the low two byte lanes of write data over an old value
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [3:0] be,
                                            input logic [31:0] wd);
    laneMerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  logic                waitQ, waitD;
  logic [31:0]         rdataQ, rdataD;
  logic [7:0]          modeQ, modeD, funcQ, funcD, omenQ, omenD;
  logic [NCH-1:0]      startQ, startD, syncQ, syncD;
  logic [8:0]          ctrlQ, ctrlD;
  logic [9:0]          irqEnQ, irqEnD, irqStatQ, irqStatD;
  logic                irqQ, irqD;
  logic [15:0]         cntQ [NCH], cntD [NCH];
  logic [15:0]         cmpAQ [NCH], cmpAD [NCH], cmpBQ [NCH], cmpBD [NCH];
  logic [15:0]         bufQ [4], bufD [4];
  logic [NCH-1:0]      pwmStQ, pwmStD, pinQ, pinD, oeQ, oeD;
  logic [2:0]          divQ, divD;
  logic [1:0]          quadS1Q, quadS2Q, quadPrevQ;
  logic [1:0]          capS1Q, capS2Q, capPrevQ;

  // Bus decode; a request is answered one cycle after it is seen
  logic                wrAck;
  logic                chHit, bufHit;
  logic [2:0]          addrCh;
  logic [1:0]          addrSel;
  logic [15:0]         wrVal;
  assign wrAck   = avs_write & ~waitQ;
  assign addrSel = avs_address[3:2];
  assign addrCh  = 3'(avs_address[7:4] - tmpc_pkg::PAGE_CH_LO);
  assign chHit   = (avs_address[7:4] >= tmpc_pkg::PAGE_CH_LO)
                 && (avs_address[7:4] <= tmpc_pkg::PAGE_CH_HI) && (addrSel != 2'h3);
  assign bufHit  = avs_address[7:4] == tmpc_pkg::PAGE_BUF;

  // Mode decode
  logic                phaseMode, flag_direction, complMode, rsyncMode, cmbMode;
  assign phaseMode = modeQ[tmpc_pkg::MODE_PHASE_BIT];
  assign flag_direction      = modeQ[tmpc_pkg::MODE_FLAG_DIRECTION_BIT];
  assign complMode = funcQ[tmpc_pkg::FUNC_CMD_LSB +: 2] == tmpc_pkg::CMD_COMPL; // [RQ10]
  assign rsyncMode = funcQ[tmpc_pkg::FUNC_CMD_LSB +: 2] == tmpc_pkg::CMD_RSYNC; // [RQ10]
  assign cmbMode   = complMode | rsyncMode;

  // Prescaler tick from a free divider
  logic                psTick;
  always_comb begin
    unique case (ctrlQ[tmpc_pkg::CTRL_PSC_LSB +: 2])
      tmpc_pkg::PSC_DIV1: psTick = 1'b1;
      tmpc_pkg::PSC_DIV2: psTick = divQ[0];
      tmpc_pkg::PSC_DIV4: psTick = &divQ[1:0];
      default:            psTick = &divQ;
    endcase
  end

  // Quadrature edges, read only from second synchroniser stage onward
  logic qa, qb, aRise, aFall, bRise, bFall, quadUp, quadDown;
  assign qa       = quadS2Q[0];
  assign qb       = quadS2Q[1];
  assign aRise    = qa & ~quadPrevQ[0];
  assign aFall    = ~qa & quadPrevQ[0];
  assign bRise    = qb & ~quadPrevQ[1];
  assign bFall    = ~qb & quadPrevQ[1];
  // Opposite phase order counts down; simultaneous edges are ambiguous and skipped
  assign quadDown = (aRise & ~qb) | (bRise & qa) | (aFall & qb) | (bFall & ~qa); // [RQ3]
  assign quadUp   = (aRise & qb) | (bRise & ~qa) | (aFall & ~qb) | (bFall & qa); // [RQ3]

  logic [1:0] capEvt;
  assign capEvt = capS2Q & ~capPrevQ & ctrlQ[tmpc_pkg::CTRL_CAP_LSB +: 2];

  // Per-channel count tick, direction, matches and clear requests
  logic [NCH-1:0] tick, up, matchA, matchB, clrReq, ovf, unf, chClear;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      if (g == tmpc_pkg::CH_PHASE) begin : g_phase
        assign up[g]   = ~(phaseMode & ~quadUp);                               // [RQ2]
        assign tick[g] = startQ[g] & (phaseMode ? (quadUp ^ quadDown) : psTick); // [RQ4]
      end else begin : g_plain
        assign up[g]   = 1'b1;
        assign tick[g] = startQ[g] & psTick;
      end
      assign matchA[g] = tick[g] & (cntQ[g] == cmpAQ[g]);
      assign matchB[g] = tick[g] & (cntQ[g] == cmpBQ[g]);
      assign ovf[g]    = tick[g] & up[g] & (cntQ[g] == tmpc_pkg::CNT_MAX);
      assign unf[g]    = tick[g] & ~up[g] & (cntQ[g] == tmpc_pkg::CNT_RST);
      // Clear on B match is still honoured in phase mode
      assign clrReq[g] = matchB[g] & (ctrlQ[tmpc_pkg::CTRL_CLRB_LSB + g] // [RQ5]
                       | ((g == tmpc_pkg::CH_CMB_LO) & rsyncMode));
      assign chClear[g] = clrReq[g] | (syncQ[g] & |(clrReq & syncQ)); // [RQ16] [RQ12]
    end
  endgenerate

  // Bus handshake, readback and control registers
  always_comb begin
    waitD  = ~((avs_read | avs_write) & waitQ);
    rdataD = rdataQ;
    modeD  = modeQ;
    funcD  = funcQ;
    omenD  = omenQ;
    startD = startQ;
    syncD  = syncQ;
    ctrlD  = ctrlQ;
    irqEnD = irqEnQ;
    if (avs_read && waitQ) begin
      rdataD = 32'h0000_0000;
      if (chHit) begin
        unique case (addrSel)
          tmpc_pkg::SEL_CNT:  rdataD[15:0] = cntQ[addrCh];
          tmpc_pkg::SEL_CMPA: rdataD[15:0] = cmpAQ[addrCh];
          default:            rdataD[15:0] = cmpBQ[addrCh];
        endcase
      end else if (bufHit) begin
        rdataD[15:0] = bufQ[addrSel];
      end else begin
        unique case (avs_address)
          tmpc_pkg::OFF_MODE:     rdataD[7:0] = modeQ;
          tmpc_pkg::OFF_FUNC:     rdataD[7:0] = funcQ;
          tmpc_pkg::OFF_OMEN:     rdataD[7:0] = omenQ;
          tmpc_pkg::OFF_START:    rdataD[NCH-1:0] = startQ;
          tmpc_pkg::OFF_SYNC:     rdataD[NCH-1:0] = syncQ;
          tmpc_pkg::OFF_CTRL:     rdataD[8:0] = ctrlQ;
          tmpc_pkg::OFF_IRQ_STAT: rdataD[9:0] = irqStatQ;
          tmpc_pkg::OFF_IRQ_EN:   rdataD[9:0] = irqEnQ;
          default:                rdataD = 32'h0000_0000;
        endcase
      end
    end
    if (wrAck && avs_byteenable[0]) begin
      unique case (avs_address)
        tmpc_pkg::OFF_MODE:  modeD  = avs_writedata[7:0] | tmpc_pkg::MODE_FIXED;  // [RQ1]
        tmpc_pkg::OFF_FUNC:  funcD  = avs_writedata[7:0] | tmpc_pkg::FUNC_FIXED;  // [RQ9]
        tmpc_pkg::OFF_OMEN:  omenD  = avs_writedata[7:0] | tmpc_pkg::OMEN_FIXED;  // [RQ15]
        tmpc_pkg::OFF_START: startD = avs_writedata[NCH-1:0];
        tmpc_pkg::OFF_SYNC:  syncD  = avs_writedata[NCH-1:0];
        default:             modeD  = modeQ;
      endcase
    end
    if (wrAck && avs_address == tmpc_pkg::OFF_CTRL) begin
      ctrlD = 9'(laneMerge({7'h00, ctrlQ}, avs_byteenable, avs_writedata));
    end
    if (wrAck && avs_address == tmpc_pkg::OFF_IRQ_EN) begin
      irqEnD = 10'(laneMerge({6'h00, irqEnQ}, avs_byteenable, avs_writedata));
    end
    // Standby holds the control registers at their reset values
    if (standby) begin
      modeD  = tmpc_pkg::MODE_RST;   // [RQ1]
      funcD  = tmpc_pkg::FUNC_RST;   // [RQ9] [RQ14]
      omenD  = tmpc_pkg::OMEN_RST;   // [RQ15]
      startD = '0;
      syncD  = '0;
      ctrlD  = '0;
      irqEnD = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      waitQ  <= 1'b1;
      rdataQ <= 32'h0000_0000;
      modeQ  <= tmpc_pkg::MODE_RST;  // [RQ1]
      funcQ  <= tmpc_pkg::FUNC_RST;  // [RQ9] [RQ14]
      omenQ  <= tmpc_pkg::OMEN_RST;  // [RQ15]
      startQ <= '0;
      syncQ  <= '0;
      ctrlQ  <= '0;
      irqEnQ <= '0;
    end else begin
      waitQ  <= waitD;
      rdataQ <= rdataD;
      modeQ  <= modeD;
      funcQ  <= funcD;
      omenQ  <= omenD;
      startQ <= startD;
      syncQ  <= syncD;
      ctrlQ  <= ctrlD;
      irqEnQ <= irqEnD;
    end
  end

  // Counters, compares, buffers, PWM state, pins and interrupt status
  always_comb begin
    divD     = divQ + 3'h1;
    pwmStD   = pwmStQ;
    bufD     = bufQ;
    wrVal    = 16'h0000;
    for (int i = 0; i < NCH; i++) begin
      cntD[i]  = cntQ[i];
      cmpAD[i] = cmpAQ[i];
      cmpBD[i] = cmpBQ[i];
      if (chClear[i]) begin
        cntD[i] = tmpc_pkg::CNT_RST;                                // [RQ16]
      end else if (tick[i]) begin
        cntD[i] = up[i] ? cntQ[i] + 16'h0001 : cntQ[i] - 16'h0001;   // [RQ2]
      end
      // B match wins when both compares hit in one tick
      if (matchB[i]) begin
        pwmStD[i] = 1'b0;                                           // [RQ7]
      end else if (matchA[i]) begin
        pwmStD[i] = 1'b1;                                           // [RQ7]
      end
    end
    // Buffer index 2c+0 is compare A, 2c+1 compare B of channel 3+c
    for (int c = 0; c < 2; c++) begin
      if (capEvt[c]) begin
        cmpAD[tmpc_pkg::CH_CMB_LO + c] = cntQ[tmpc_pkg::CH_CMB_LO + c];
        if (funcQ[2*c]) begin
          bufD[2*c] = cmpAQ[tmpc_pkg::CH_CMB_LO + c];                // [RQ17]
        end
      end else if (funcQ[2*c] && matchA[tmpc_pkg::CH_CMB_LO + c]) begin
        cmpAD[tmpc_pkg::CH_CMB_LO + c] = bufQ[2*c];                  // [RQ14] [RQ17]
      end
      if (funcQ[2*c+1] && matchB[tmpc_pkg::CH_CMB_LO + c]) begin
        cmpBD[tmpc_pkg::CH_CMB_LO + c] = bufQ[2*c+1];                // [RQ14] [RQ17]
      end
    end
    // Bus writes land after counting, capture and reloads, before standby; a synchronised counter write presets all synced
    if (wrAck && chHit) begin
      unique case (addrSel)
        tmpc_pkg::SEL_CNT: begin
          wrVal = laneMerge(cntQ[addrCh], avs_byteenable, avs_writedata);
          for (int i = 0; i < NCH; i++) begin
            if (3'(i) == addrCh || (syncQ[i] && syncQ[addrCh])) begin
              cntD[i] = wrVal;                                      // [RQ16]
            end
          end
        end
        tmpc_pkg::SEL_CMPA: cmpAD[addrCh] = laneMerge(cmpAQ[addrCh], avs_byteenable,
                                                      avs_writedata);
        default:            cmpBD[addrCh] = laneMerge(cmpBQ[addrCh], avs_byteenable,
                                                      avs_writedata);
      endcase
    end
    if (wrAck && bufHit) begin
      bufD[addrSel] = laneMerge(bufQ[addrSel], avs_byteenable, avs_writedata);
    end
    // Pin drive: PWM select per channel, combined modes take channels 3 and 4
    for (int i = 0; i < NCH; i++) begin
      pinD[i] = pwmStQ[i];
      oeD[i]  = modeQ[i];                                            // [RQ7]
    end
    if (cmbMode) begin
      oeD[tmpc_pkg::CH_CMB_LO]     = 1'b1;                           // [RQ8]
      oeD[tmpc_pkg::CH_CMB_LO + 1] = 1'b1;                           // [RQ8]
      if (complMode) begin
        pinD[tmpc_pkg::CH_CMB_LO + 1] = ~pwmStQ[tmpc_pkg::CH_CMB_LO]; // [RQ10]
      end
    end
    oeD[tmpc_pkg::CH_CMB_LO]     = oeD[tmpc_pkg::CH_CMB_LO] & omenQ[tmpc_pkg::OMEN_EA3_BIT];
    oeD[tmpc_pkg::CH_CMB_LO + 1] = oeD[tmpc_pkg::CH_CMB_LO + 1]
                                 & omenQ[tmpc_pkg::OMEN_EA4_BIT];
    pinD = pinD & oeD;
    // Sticky status: a set in the clearing cycle survives
    irqStatD = irqStatQ;
    if (wrAck && avs_address == tmpc_pkg::OFF_IRQ_CLR) begin
      irqStatD = irqStatQ & ~10'(laneMerge(16'h0000, avs_byteenable, avs_writedata));
    end
    irqStatD[tmpc_pkg::IRQ_OVF_LSB +: NCH] = irqStatD[tmpc_pkg::IRQ_OVF_LSB +: NCH]
                                           | ovf | (unf & {NCH{~flag_direction}});  // [RQ6] [RQ5]
    irqStatD[tmpc_pkg::IRQ_CMPA_LSB +: NCH] = irqStatD[tmpc_pkg::IRQ_CMPA_LSB +: NCH]
                                            | matchA;                     // [RQ5]
    if (standby) begin
      for (int i = 0; i < NCH; i++) begin
        cntD[i]  = tmpc_pkg::CNT_RST;
        cmpAD[i] = tmpc_pkg::CMP_RST;
        cmpBD[i] = tmpc_pkg::CMP_RST;
      end
      for (int b = 0; b < tmpc_pkg::NUM_BUF; b++) begin
        bufD[b] = tmpc_pkg::CMP_RST;
      end
      pwmStD   = '0;
      pinD     = '0;
      oeD      = '0;
      irqStatD = '0;
    end
    irqD = |(irqStatD & irqEnD);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      divQ     <= '0;
      pwmStQ   <= '0;
      pinQ     <= '0;
      oeQ      <= '0;
      irqStatQ <= '0;
      irqQ     <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        cntQ[i]  <= tmpc_pkg::CNT_RST;
        cmpAQ[i] <= tmpc_pkg::CMP_RST;
        cmpBQ[i] <= tmpc_pkg::CMP_RST;
      end
      for (int b = 0; b < tmpc_pkg::NUM_BUF; b++) begin
        bufQ[b] <= tmpc_pkg::CMP_RST;
      end
    end else begin
      divQ     <= divD;
      pwmStQ   <= pwmStD;
      pinQ     <= pinD;
      oeQ      <= oeD;
      irqStatQ <= irqStatD;
      irqQ     <= irqD;
      cntQ     <= cntD;
      cmpAQ    <= cmpAD;
      cmpBQ    <= cmpBD;
      bufQ     <= bufD;
    end
  end

  // Pin synchronisers; stage one feeds stage two only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      quadS1Q   <= '0;
      quadS2Q   <= '0;
      quadPrevQ <= '0;
      capS1Q    <= '0;
      capS2Q    <= '0;
      capPrevQ  <= '0;
    end else begin
      quadS1Q   <= {quadratureInB, quadratureInA};
      quadS2Q   <= quadS1Q;
      quadPrevQ <= quadS2Q;
      capS1Q    <= captureIn;
      capS2Q    <= capS1Q;
      capPrevQ  <= capS2Q;
    end
  end

  assign avs_readdata    = rdataQ;
  assign avs_waitrequest = waitQ;
  assign pwmPin          = pinQ;
  assign pwmOe           = oeQ;
  assign irq             = irqQ;
endmodule // tmpc_timer

// ---- tmpc_timer_asserts.sv ----
`timescale 1ns/10ps
module tmpc_timer_asserts (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        standby,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [4:0]  pwmPin,
  input wire logic [4:0]  pwmOe,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Bus answers after exactly one wait cycle, one cycle wide
  property p_waitOne;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_waitOne: assert property (p_waitOne) else $error("request not answered in one cycle");
  property p_ackShort;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ackShort: assert property (p_ackShort) else $error("acknowledge longer than one cycle");
  property p_noAck;
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_noAck: assert property (p_noAck) else $error("acknowledge without request");

  // Fixed bits read as one whatever was written; the unmapped 0x4C reads zero
  property p_modeRd;
    avs_read && avs_waitrequest && avs_address == tmpc_pkg::OFF_MODE |=> avs_readdata[7];
  endproperty
  a_modeRd: assert property (p_modeRd) else $error("mode bit 7 read as zero");
  property p_funcRd;
    avs_read && avs_waitrequest && avs_address == tmpc_pkg::OFF_FUNC
      |=> avs_readdata[7:6] == 2'h3;
  endproperty
  a_funcRd: assert property (p_funcRd) else $error("function bits 7:6 not one");
  property p_omenRd;
    avs_read && avs_waitrequest && avs_address == tmpc_pkg::OFF_OMEN
      |=> avs_readdata[7:6] == 2'h3;
  endproperty
  a_omenRd: assert property (p_omenRd) else $error("master enable bits 7:6 not one");
  property p_hole;
    avs_read && avs_waitrequest && avs_address == 8'h4C |=> avs_readdata == 32'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");

  // A pin is never driven high while its enable is off
  property p_pinOe;
    (pwmPin & ~pwmOe) == 5'h00;
  endproperty
  a_pinOe: assert property (p_pinOe) else $error("pin high without enable");
  // Standby resets mode to 0x80 and clears enables, so pins and interrupt go quiet
  property p_standby;
    standby [*2] |=> pwmOe == 5'h00 && !irq;
  endproperty
  a_standby: assert property (p_standby) else $error("outputs alive in standby");

  c_write: cover property (avs_write && !avs_waitrequest);
  c_pwm: cover property ($rose(pwmPin[0]));
  c_irq: cover property ($rose(irq));
endmodule // tmpc_timer_asserts

bind tmpc_timer tmpc_timer_asserts u_chk (
  .sys_clk        (sys_clk),
  .reset          (reset),
  .standby        (standby),
  .avs_address    (avs_address),
  .avs_read       (avs_read),
  .avs_write      (avs_write),
  .avs_readdata   (avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .pwmPin         (pwmPin),
  .pwmOe          (pwmOe),
  .irq            (irq)
);
